// File: rtl/pbd_defs.vh
// constants for the packet buffer dma block
//
// What this block does
// - rejected frame rewinds receive dma to current page
// - no rewind when bad frames are accepted
// - received crc bytes stored after data
// - layout from byte order and word select
// - word mode byte order swaps data bytes
// - byte mode header: status, pointer, counts
// - transmit dma uses page start and count
// - device adds preamble, sync and crc
// - core width follows word transfer select
// - request clears status, prefetch unless receiving
// - start needs gap, fifo byte, backoff done
// - early carrier makes device give up
// - collision flushes, restores, flags, counts
// - fifteen failed retries abort the frame
// - collision count reads zero after abort
// - bytes ascending, bits least significant first
// - pages are 256 bytes, checked at crossing
// - header at first page, next frame next page
`ifndef PBD_DEFS_VH
`define PBD_DEFS_VH
`define PBD_CLK_NS       4
`define PBD_BIT_NS       100
`define PBD_IFG_NS       6400
`define PBD_BACKOFF_CYC  12800
`define PBD_HDR_OFS      8'h04
`define PBD_PAGE_BASE    8'h00
`define PBD_PAGE_LAST    8'hFF
`define PBD_PRE_LAST     6'h3F
`define PBD_BYTE_LAST    3'h7
`define PBD_CRC_LAST     5'h1F
`define PBD_CRC_POLY     32'hEDB88320
`define PBD_CRC_INIT     32'hFFFFFFFF
`define PBD_MAX_RETRY    4'hF
`define PBD_FIFO_DEPTH   16
`define PBD_FIFO_AW      4
`endif

// File: rtl/pbd_packet_buffer_dma.v
// transmit fifo and the packet buffer dma engine
`timescale 1ns/1ps
`include "pbd_defs.vh"

module pbd_fifo #(
	parameter W  = 8,
	parameter D  = `PBD_FIFO_DEPTH,
	parameter AW = `PBD_FIFO_AW
) (
	// clock and reset
	input  wire          core_clk,
	input  wire          rst_b,
	input  wire          flush,
	// fill side
	input  wire          inValid,
	output wire          inReady,
	input  wire [W-1:0]  inData,
	// drain side
	output wire          outValid,
	input  wire          outReady,
	output wire [W-1:0]  outData,
	output wire [AW:0]   count
);
	reg [W-1:0] mem [0:D-1];   // storage array
	reg [AW:0]  wrPtr;         // write pointer with wrap bit
	reg [AW:0]  rdPtr;         // read pointer with wrap bit

	assign count    = wrPtr - rdPtr;
	assign inReady  = (count != D[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr[AW-1:0]];

	// storage write
	always @(posedge core_clk) begin
		if (inValid && inReady)
			mem[wrPtr[AW-1:0]] <= inData;
	end

	// pointers, flush empties the fifo
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr <= {(AW+1){1'b0}};
			rdPtr <= {(AW+1){1'b0}};
		end else if (flush) begin
			rdPtr <= wrPtr;
		end else begin
			if (inValid && inReady)
				wrPtr <= wrPtr + 1'b1;
			if (outValid && outReady)
				rdPtr <= rdPtr + 1'b1;
		end
	end
endmodule // pbd_fifo

module pbd_packet_buffer_dma #(
	parameter BACKOFF_CYC = `PBD_BACKOFF_CYC,
	parameter FIFO_DEPTH  = `PBD_FIFO_DEPTH,
	parameter FIFO_AW     = `PBD_FIFO_AW
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	// configuration
	input  wire        byteOrderSelect,
	input  wire        wordTransferSelect,
	input  wire        acceptRunt,
	input  wire        acceptErrors,
	input  wire [7:0]  ringPageStart,
	input  wire [7:0]  ringPageStop,
	input  wire [7:0]  ringBoundary,
	input  wire        curLoad,
	input  wire [7:0]  curLoadValue,
	// transmit setup
	input  wire [7:0]  txPageStart,
	input  wire [7:0]  txByteCountLow,
	input  wire [7:0]  txByteCountHigh,
	input  wire        transmitRequest,
	// receive byte stream
	input  wire        rxActive,
	input  wire        rxByteValid,
	input  wire [7:0]  rxByte,
	input  wire        rxEnd,
	input  wire [7:0]  rxStatus,
	input  wire        rxRunt,
	input  wire        rxCrcError,
	input  wire        rxAlignError,
	// line pins
	input  wire        carrierSense,
	input  wire        collision,
	output reg         txData,
	output reg         txEnable,
	// buffer memory
	output reg  [15:0] memAddr,
	output reg  [15:0] memWrData,
	output reg  [1:0]  memByteEn,
	output reg         memWrEn,
	output reg         memRdEn,
	input  wire [15:0] memRdData,
	input  wire        memRdValid,
	// status
	output reg  [7:0]  currentPagePointer,
	output reg         txDone,
	output reg         txCollided,
	output reg         txAborted,
	output reg         txUnderrun,
	output reg  [3:0]  collisionCount
);
	localparam BIT_CYC = `PBD_BIT_NS / `PBD_CLK_NS;                       // cycles per bit
	localparam IFG_CYC = (`PBD_IFG_NS + `PBD_CLK_NS - 1) / `PBD_CLK_NS;   // gap, rounded up
	// receive states
	localparam [2:0] R_IDLE = 3'h1, R_DATA = 3'h2, R_HDR = 3'h4;
	// transmit states
	localparam [6:0] T_IDLE = 7'h01, T_WAIT = 7'h02, T_PRE  = 7'h04, T_DATA = 7'h08,
	                 T_CRC  = 7'h10, T_DONE = 7'h20, T_BACK = 7'h40;

	// byte lane for a byte address in the buffer
	function [1:0] laneMask;
		input a0;
		input swap;
		input wide;
		begin
			laneMask = (wide && (a0 ^ swap)) ? 2'h2 : 2'h1;
		end
	endfunction

	// next ring page with wrap at the stop page
	function [7:0] nextPage;
		input [7:0] p;
		input [7:0] pStart;
		input [7:0] pStop;
		begin
			nextPage = ((p + 8'h01) == pStop) ? pStart : (p + 8'h01);
		end
	endfunction

	// pin synchronisers, three stages
	reg [2:0] csSync;       // carrier sense chain
	reg [2:0] colSync;      // collision chain
	reg       carrierQ;     // filtered carrier
	reg       collisionQ;   // filtered collision
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			csSync     <= 3'h0;
			colSync    <= 3'h0;
			carrierQ   <= 1'b0;
			collisionQ <= 1'b0;
		end else begin
			csSync  <= {csSync[1:0], carrierSense};
			colSync <= {colSync[1:0], collision};
			if (csSync[1] == csSync[2])
				carrierQ <= csSync[2];
			if (colSync[1] == colSync[2])
				collisionQ <= colSync[2];
		end
	end

	// receive side state
	reg [2:0]  rxState;     // receive state
	reg [15:0] rxAddr;      // next free byte address
	reg [15:0] rxCount;     // bytes stored, crc included
	reg        rxOverflow;  // ring hit the boundary
	reg [1:0]  hdrIdx;      // header byte index
	reg [7:0]  nextPkt;     // page for the next frame
	reg [7:0]  hdrByte;     // header byte mux
	wire [15:0] wrAddr  = (rxState == R_IDLE) ? {currentPagePointer, `PBD_HDR_OFS} : rxAddr;
	wire        rxWr    = rxByteValid && !rxOverflow && (rxState != R_HDR);
	wire        hdrWr   = (rxState == R_HDR);
	wire        rxReject = (rxRunt && !acceptRunt) || ((rxCrcError || rxAlignError)
	                       && !acceptErrors) || rxOverflow;
	wire [7:0]  wrPage  = nextPage(wrAddr[15:8], ringPageStart, ringPageStop);

	// header byte order: status, pointer, count low, count high
	always @* begin
		case (hdrIdx)
			2'h0:    hdrByte = rxStatus;
			2'h1:    hdrByte = nextPkt;
			2'h2:    hdrByte = rxCount[7:0];
			default: hdrByte = rxCount[15:8];
		endcase
	end

	// receive dma and buffer header
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxState            <= R_IDLE;
			rxAddr             <= 16'h0000;
			rxCount            <= 16'h0000;
			rxOverflow         <= 1'b0;
			hdrIdx             <= 2'h0;
			nextPkt            <= 8'h00;
			currentPagePointer <= 8'h00;
		end else begin
			case (rxState)
				R_IDLE, R_DATA: begin
					// every byte goes in until the ring hits the boundary, crc bytes trail the data
					if (rxWr) begin
						rxState <= R_DATA;
						rxCount <= (rxState == R_IDLE) ? 16'h0001 : rxCount + 16'h0001;
						if (wrAddr[7:0] == `PBD_PAGE_LAST) begin
							rxAddr <= {wrPage, `PBD_PAGE_BASE};
							if (wrPage == ringBoundary)
								rxOverflow <= 1'b1;
						end else begin
							rxAddr <= wrAddr + 16'h0001;
						end
					end
					if (rxEnd && rxState == R_DATA) begin
						// reject: nothing to do, dma restarts at current page
						if (rxReject) begin
							rxState <= R_IDLE;
						end else begin
							rxState <= R_HDR;
							hdrIdx  <= 2'h0;
							nextPkt <= (rxAddr[7:0] == `PBD_PAGE_BASE) ? rxAddr[15:8]
							           : nextPage(rxAddr[15:8], ringPageStart, ringPageStop);
						end
						rxOverflow <= 1'b0;
					end
				end
				R_HDR: begin
					hdrIdx <= hdrIdx + 2'h1;
					// last header byte: advance to the next free page
					if (hdrIdx == 2'h3) begin
						rxState            <= R_IDLE;
						currentPagePointer <= nextPkt;
					end
				end
				default: rxState <= R_IDLE;
			endcase
			// host load of the current page when idle
			if (curLoad && rxState == R_IDLE && !rxWr)
				currentPagePointer <= curLoadValue;
		end
	end

	// transmit side state
	reg [6:0]  txState;      // transmit state
	reg        txPending;    // request outstanding
	reg [15:0] txAddr;       // fetch address
	reg [15:0] txRemain;     // bytes still to fetch
	reg        rdOutstanding;// read in flight
	reg        rdDiscard;    // drop the read in flight
	reg        rdHigh;       // read byte sits in upper lane
	reg [4:0]  bitCnt;       // cycles within a bit
	reg [10:0] gapCnt;       // interframe gap timer
	reg [23:0] backCnt;      // backoff timer
	reg [5:0]  preIdx;       // preamble bit index
	reg [2:0]  bitIdx;       // data bit index
	reg [4:0]  crcIdx;       // crc bit index
	reg [7:0]  txShift;      // byte being sent
	reg [31:0] crc;          // running crc
	reg [3:0]  retryCnt;     // collisions of this frame
	reg        fifoFlush;    // flush pulse to the fifo
	reg        fifoPop;      // take one byte
	wire [FIFO_AW:0] fifoCount;
	wire       fifoInReady;
	wire       fifoOutValid;
	wire [7:0] fifoOutData;
	wire       bitTick  = (bitCnt == BIT_CYC[4:0] - 5'h01);
	wire       ifgDone  = (gapCnt >= IFG_CYC[10:0]);
	wire       fetchOn  = (txState == T_WAIT) || (txState == T_PRE) || (txState == T_DATA);
	wire       fetchDone = (txRemain == 16'h0000) && !rdOutstanding;
	wire       onLine   = (txState == T_PRE) || (txState == T_DATA) || (txState == T_CRC)
	                      || (txState == T_DONE);
	// fetch stalls while the fifo has no room or receive owns memory
	wire       txIssue  = fetchOn && (txRemain != 16'h0000) && !rdOutstanding && !rxWr
	                      && !hdrWr && fifoInReady
	                      && (fifoCount < FIFO_DEPTH[FIFO_AW:0] - 1'b1);
	wire       fifoPush = memRdValid && rdOutstanding && !rdDiscard;
	wire [7:0] rdByte   = rdHigh ? memRdData[15:8] : memRdData[7:0];
	wire       crcFb    = crc[0] ^ txShift[0];

	pbd_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) uFifo (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.flush    (fifoFlush),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.inData   (rdByte),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData),
		.count    (fifoCount)
	);

	// gap timer runs while the line is quiet
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			gapCnt <= 11'h000;
		else if (carrierQ || txEnable)
			gapCnt <= 11'h000;
		else if (!ifgDone)
			gapCnt <= gapCnt + 11'h001;
	end

	// transmit fetch, serializer, collision handling
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			txState <= T_IDLE;     txPending <= 1'b0;     txAddr <= 16'h0000;
			txRemain <= 16'h0000;  rdOutstanding <= 1'b0; rdDiscard <= 1'b0;
			rdHigh <= 1'b0;        bitCnt <= 5'h00;       backCnt <= 24'h000000;
			preIdx <= 6'h00;       bitIdx <= 3'h0;        crcIdx <= 5'h00;
			txShift <= 8'h00;      crc <= `PBD_CRC_INIT;  retryCnt <= 4'h0;
			fifoFlush <= 1'b0;     fifoPop <= 1'b0;       txData <= 1'b0;
			txEnable <= 1'b0;      txDone <= 1'b0;        txCollided <= 1'b0;
			txAborted <= 1'b0;     txUnderrun <= 1'b0;    collisionCount <= 4'h0;
		end else begin
			fifoFlush <= 1'b0;
			fifoPop   <= 1'b0;
			bitCnt    <= bitTick ? 5'h00 : bitCnt + 5'h01;
			// one read in flight, lane chosen by core width and byte order
			if (txIssue) begin
				rdOutstanding <= 1'b1;
				rdHigh   <= laneMask(txAddr[0], byteOrderSelect, wordTransferSelect) == 2'h2;
				txAddr   <= txAddr + 16'h0001;
				txRemain <= txRemain - 16'h0001;
			end else if (memRdValid) begin
				rdOutstanding <= 1'b0;
				rdDiscard     <= 1'b0;
			end
			// new request clears status
			if (transmitRequest) begin
				txPending  <= 1'b1;
				txDone     <= 1'b0;
				txCollided <= 1'b0;
				txAborted  <= 1'b0;
				txUnderrun <= 1'b0;
				retryCnt   <= 4'h0;
				collisionCount <= 4'h0;
			end
			case (txState)
				T_IDLE: begin
					// no prefetch while a frame is coming in
					if (txPending && !rxActive && !carrierQ && !rdOutstanding) begin
						txState  <= T_WAIT;
						txAddr   <= {txPageStart, `PBD_PAGE_BASE};
						txRemain <= {txByteCountHigh, txByteCountLow};
						fifoFlush <= 1'b1;  // drop bytes of a given-up try
					end
				end
				T_WAIT: begin
					if (carrierQ && !fifoOutValid) begin
						txState <= T_IDLE;
					end else if (ifgDone && fifoOutValid) begin
						txState  <= T_PRE;
						txEnable <= 1'b1;
						txData   <= 1'b1;
						preIdx   <= 6'h01;
						bitCnt   <= 5'h00;
						crc      <= `PBD_CRC_INIT;
					end
				end
				T_PRE: begin
					if (bitTick) begin
						// alternating bits, final pair of ones ends the sync
						txData <= (preIdx == `PBD_PRE_LAST) | ~preIdx[0];
						preIdx <= preIdx + 6'h01;
						if (preIdx == `PBD_PRE_LAST) begin
							txState <= T_DATA;
							txShift <= fifoOutData;
							fifoPop <= 1'b1;
							bitIdx  <= 3'h0;
						end
					end
				end
				T_DATA: begin
					if (bitTick) begin
						txData  <= txShift[0];
						txShift <= {1'b0, txShift[7:1]};
						crc     <= {1'b0, crc[31:1]} ^ (crcFb ? `PBD_CRC_POLY : 32'h00000000);
						bitIdx  <= bitIdx + 3'h1;
						if (bitIdx == `PBD_BYTE_LAST) begin
							if (fifoOutValid && !fifoPop) begin
								txShift <= fifoOutData;
								fifoPop <= 1'b1;
							end else if (fetchDone) begin
								txState <= T_CRC;
								crcIdx  <= 5'h00;
							end else begin
								txUnderrun <= 1'b1;
								txPending  <= 1'b0;
								txState    <= T_DONE;
							end
						end
					end
				end
				T_CRC: begin
					if (bitTick) begin
						txData <= ~crc[0];
						crc    <= {1'b0, crc[31:1]};
						crcIdx <= crcIdx + 5'h01;
						if (crcIdx == `PBD_CRC_LAST)
							txState <= T_DONE;
					end
				end
				T_DONE: begin
					if (bitTick) begin
						txEnable  <= 1'b0;
						txData    <= 1'b0;
						txDone    <= !txUnderrun;
						txPending <= 1'b0;
						txState   <= T_IDLE;
					end
				end
				T_BACK: begin
					backCnt <= backCnt + 24'h000001;
					if (backCnt >= BACKOFF_CYC[23:0] - 24'h000001)
						txState <= T_IDLE;
				end
				default: txState <= T_IDLE;
			endcase
			// collision on the line overrides the frame in progress
			if (collisionQ && onLine) begin
				txEnable   <= 1'b0;
				txData     <= 1'b0;
				fifoFlush  <= 1'b1;
				rdDiscard  <= (rdOutstanding & !memRdValid) | txIssue;
				txCollided <= 1'b1;
				if (retryCnt == `PBD_MAX_RETRY) begin
					txAborted      <= 1'b1;
					collisionCount <= 4'h0;
					txPending      <= 1'b0;
					txState        <= T_IDLE;
				end else begin
					retryCnt       <= retryCnt + 4'h1;
					collisionCount <= collisionCount + 4'h1;
					backCnt        <= 24'h000000;
					txState        <= T_BACK;
				end
			end
		end
	end

	// memory port: receive writes first, then transmit reads
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			memAddr   <= 16'h0000;
			memWrData <= 16'h0000;
			memByteEn <= 2'h0;
			memWrEn   <= 1'b0;
			memRdEn   <= 1'b0;
		end else begin
			memWrEn <= rxWr || hdrWr;
			memRdEn <= txIssue;
			if (rxWr) begin
				memAddr   <= wrAddr;
				memWrData <= {rxByte, rxByte};
				memByteEn <= laneMask(wrAddr[0], byteOrderSelect, wordTransferSelect);
			end else if (hdrWr) begin
				memAddr   <= {currentPagePointer, 6'h00, hdrIdx};
				memWrData <= {hdrByte, hdrByte};
				// status and pointer lanes fixed, counts follow byte order
				memByteEn <= laneMask(hdrIdx[0], byteOrderSelect & hdrIdx[1],
				                      wordTransferSelect);
			end else if (txIssue) begin
				memAddr   <= txAddr;
				memByteEn <= laneMask(txAddr[0], byteOrderSelect, wordTransferSelect);
			end
		end
	end
endmodule // pbd_packet_buffer_dma

// File: bench/pbd_dma_assertions.sv
// port assertions for the packet buffer dma
`timescale 1ns/1ps
module pbd_dma_assertions (
	// clock and reset
	input wire        core_clk,
	input wire        rst_b,
	// configuration
	input wire        byteOrderSelect,
	input wire        wordTransferSelect,
	input wire        acceptRunt,
	input wire        acceptErrors,
	// transmit setup
	input wire [7:0]  txPageStart,
	input wire [7:0]  txByteCountLow,
	input wire [7:0]  txByteCountHigh,
	input wire        transmitRequest,
	// receive side
	input wire        rxActive,
	input wire        rxByteValid,
	input wire        rxEnd,
	input wire        rxRunt,
	input wire        rxCrcError,
	input wire        rxAlignError,
	// line and memory
	input wire        collision,
	input wire        txEnable,
	input wire [15:0] memAddr,
	input wire [1:0]  memByteEn,
	input wire        memWrEn,
	input wire        memRdEn,
	// status
	input wire        txDone,
	input wire        txCollided,
	input wire        txAborted,
	input wire [3:0]  collisionCount
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// frame dropped by its error flags
	wire rej = (rxRunt & ~acceptRunt) | ((rxCrcError | rxAlignError) & ~acceptErrors);
	// lane a byte write belongs in
	wire [1:0] lane = (wordTransferSelect & (memAddr[0] ^ byteOrderSelect)) ? 2'b10 : 2'b01;
	// first byte of the transmit image
	wire [15:0] txBase = {txPageStart, 8'h00};
	// quiet cycles since the line was driven
	logic [15:0] idleCnt;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			idleCnt <= 16'h0000;
		else if (txEnable)
			idleCnt <= 16'h0000;
		else if (idleCnt != 16'hFFFF)
			idleCnt <= idleCnt + 16'h0001;
	end
	// header: status, pointer, count low, count high
	sequence hdr_s;
		memWrEn && memAddr[7:0] == 8'h00 && memByteEn == 2'b01 ##1
		memWrEn && memAddr[7:0] == 8'h01 && memByteEn == {wordTransferSelect, !wordTransferSelect}
		##1 memWrEn && memAddr[7:0] == 8'h02 && memByteEn == lane
		##1 memWrEn && memAddr[7:0] == 8'h03 && memByteEn == lane;
	endsequence
	wr_byte_a: assert property (rxByteValid |=> memWrEn && memByteEn == lane)
		else $error("received byte not written in its lane");
	rej_quiet_a: assert property (rxEnd && rej |=> !memWrEn [*5])
		else $error("header written for a rejected frame");
	acc_hdr_a: assert property (rxEnd && !rej |=> ##1 hdr_s)
		else $error("header writes out of order");
	fetch_range_a: assert property (memRdEn |-> memAddr >= txBase &&
		memAddr < txBase + {txByteCountHigh, txByteCountLow})
		else $error("fetch outside the transmit image");
	rx_no_fetch_a: assert property (transmitRequest && rxActive |=> !memRdEn [*3])
		else $error("prefetch while receiving");
	req_clear_a: assert property (transmitRequest |=>
		!txDone && !txCollided && !txAborted && collisionCount == 4'h0)
		else $error("status not cleared by request");
	col_step_a: assert property ($changed(collisionCount) && collisionCount != 4'h0
		|-> collisionCount == $past(collisionCount) + 4'h1)
		else $error("collision count skipped");
	abort_zero_a: assert property (txAborted |-> collisionCount == 4'h0)
		else $error("collision count nonzero after abort");
	gap_wait_a: assert property ($rose(txEnable) |-> idleCnt >= 16'h063F)
		else $error("transmit started inside the gap");
	col_stop_a: assert property (collision && txEnable |-> ##[1:12] !txEnable)
		else $error("line still driven after collision");
endmodule // pbd_dma_assertions

bind pbd_packet_buffer_dma pbd_dma_assertions u_chk (
	.core_clk, .rst_b, .byteOrderSelect, .wordTransferSelect, .acceptRunt, .acceptErrors,
	.txPageStart, .txByteCountLow, .txByteCountHigh, .transmitRequest, .rxActive,
	.rxByteValid, .rxEnd, .rxRunt, .rxCrcError, .rxAlignError, .collision, .txEnable,
	.memAddr, .memByteEn, .memWrEn, .memRdEn, .txDone, .txCollided, .txAborted,
	.collisionCount
);

// File: bench/pbd_mem_model.sv
// buffer memory holding the host-built transmit frame
`timescale 1ns/1ps
module pbd_mem_model (
	// clock and reset
	input  wire         core_clk,
	input  wire         rst_b,
	// layout and pace
	input  wire         wordTransferSelect,
	input  wire         byteOrderSelect,
	input  wire         slow,
	// read port
	input  wire  [15:0] memAddr,
	input  wire         memRdEn,
	output logic [15:0] memRdData,
	output logic        memRdValid
);
	logic [15:0] addr;    // address being answered
	logic [2:0]  waitCnt; // cycles left before the answer
	logic        busy;    // one read outstanding
	// frame byte the host stored at an address, contiguous
	function automatic [7:0] pat(input [15:0] a);
		pat = a[7:0] * 8'h1D + a[15:8] + 8'h3B;
	endfunction
	// word image per byte order, or bytes in the low lane
	function automatic [15:0] word(input [15:0] a);
		if (!wordTransferSelect)
			word = {~pat(a), pat(a)};
		else if (byteOrderSelect)
			word = {pat(a & 16'hFFFE), pat(a | 16'h0001)};
		else
			word = {pat(a | 16'h0001), pat(a & 16'hFFFE)};
	endfunction
	// answer after one or four cycles; idle data toggles
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			memRdValid <= 1'b0;
			memRdData <= 16'h0000;
		end else begin
			memRdValid <= 1'b0;
			memRdData <= ~memRdData;
			if (memRdEn) begin
				busy <= 1'b1;
				addr <= memAddr;
				waitCnt <= slow ? 3'h3 : 3'h0;
			end else if (busy && waitCnt != 3'h0) begin
				waitCnt <= waitCnt - 3'h1;
			end else if (busy) begin
				busy <= 1'b0;
				memRdValid <= 1'b1;
				memRdData <= word(addr);
			end
		end
	end
endmodule // pbd_mem_model

// File: bench/pbd_packet_buffer_dma_tb.sv
// self-checking bench for the packet buffer dma
`timescale 1ns/1ps
module pbd_packet_buffer_dma_tb;
	logic        core_clk = 1'b0, rst_b = 1'b0, slow = 1'b0, txSeen = 1'b0;
	logic        byteOrderSelect = 1'b0, wordTransferSelect = 1'b0, curLoad = 1'b0;
	logic        acceptRunt = 1'b0, acceptErrors = 1'b0, transmitRequest = 1'b0;
	logic [7:0]  curLoadValue = 8'h5F, txPageStart = 8'h10, rxByte = 8'h00, rxStatus = 8'h00;
	logic [7:0]  txByteCountLow = 8'h3C, txByteCountHigh = 8'h00, expCur = 8'h00;
	logic        rxActive = 1'b0, rxByteValid = 1'b0, rxEnd = 1'b0, rxRunt = 1'b0;
	logic        rxCrcError = 1'b0, rxAlignError = 1'b0, carrierSense = 1'b0, collision = 1'b0;
	wire         txData, txEnable, memWrEn, memRdEn, memRdValid;
	wire         txDone, txCollided, txAborted, txUnderrun;
	wire  [15:0] memAddr, memWrData, memRdData;
	wire  [1:0]  memByteEn;
	wire  [7:0]  currentPagePointer;
	wire  [3:0]  collisionCount;
	int          nMismatch = 0, nTests = 0, m;
	logic [31:0] rnd = 32'hBEF35DF5; // stimulus shift register
	logic [25:0] wq[$];              // seen writes: address, lanes, byte
	pbd_packet_buffer_dma #(.BACKOFF_CYC(50)) u_dut (
		.core_clk, .rst_b, .byteOrderSelect, .wordTransferSelect, .acceptRunt, .acceptErrors,
		.ringPageStart(8'h40), .ringPageStop(8'h60), .ringBoundary(8'h50), .curLoad,
		.curLoadValue, .txPageStart, .txByteCountLow, .txByteCountHigh, .transmitRequest,
		.rxActive, .rxByteValid, .rxByte, .rxEnd, .rxStatus, .rxRunt, .rxCrcError,
		.rxAlignError, .carrierSense, .collision, .txData, .txEnable, .memAddr, .memWrData,
		.memByteEn, .memWrEn, .memRdEn, .memRdData, .memRdValid, .currentPagePointer,
		.txDone, .txCollided, .txAborted, .txUnderrun, .collisionCount
	);
	pbd_mem_model u_mem (.core_clk, .rst_b, .wordTransferSelect, .byteOrderSelect, .slow,
		.memAddr, .memRdEn, .memRdData, .memRdValid);
	// 250 MHz clock
	always #2 core_clk = ~core_clk;
	// log buffer writes, note any line activity
	always @(posedge core_clk) begin
		if (memWrEn === 1'b1)
			wq.push_back({memAddr, memByteEn, memWrData[7:0]});
		if (txEnable === 1'b1)
			txSeen <= 1'b1;
	end
	// frame byte the memory model holds
	function automatic [7:0] pat(input [15:0] a);
		pat = a[7:0] * 8'h1D + a[15:8] + 8'h3B;
	endfunction
	// next value of the stimulus shift register
	function automatic [31:0] lfsr(input [31:0] r);
		lfsr = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
	endfunction
	// expected lane for a stored byte
	function automatic [1:0] lane(input [15:0] a);
		lane = (wordTransferSelect & (a[0] ^ byteOrderSelect)) ? 2'b10 : 2'b01;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			nMismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic printVerdict;
		$display("checks %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one received frame of n bytes, then its stored image
	task automatic rxFrame(input int n, input logic [2:0] err, input logic keep);
		logic [25:0] e[$];
		logic [15:0] a;
		logic [7:0]  nxt;
		int          i;
		wq.delete();
		a = {expCur, 8'h04};
		{rxActive, carrierSense} = 2'b11;
		for (i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			rxByte = rnd[7:0];
			rxByteValid = 1'b1;
			e.push_back({a + 16'(i), lane(a + 16'(i)), rnd[7:0]});
			@(negedge core_clk);
			rxByteValid = 1'b0;
			@(negedge core_clk);
		end
		rxStatus = rnd[15:8];
		{rxRunt, rxCrcError, rxAlignError} = err;
		rxEnd = 1'b1;
		@(negedge core_clk);
		rxEnd = 1'b0;
		repeat (6) @(negedge core_clk);
		{rxActive, carrierSense, rxRunt, rxCrcError, rxAlignError} = 5'h00;
		nxt = expCur + 8'((n + 259) / 256);
		if (nxt >= 8'h60)
			nxt = nxt - 8'h20;
		if (keep) begin
			e.push_back({expCur, 8'h00, 2'b01, rxStatus});
			e.push_back({expCur, 8'h01, wordTransferSelect, !wordTransferSelect, nxt});
			e.push_back({expCur, 8'h02, lane(16'h0002), 8'(n)});
			e.push_back({expCur, 8'h03, lane(16'h0003), 8'(n >> 8)});
			expCur = nxt;
		end
		chk("write count", e.size(), wq.size());
		for (i = 0; i < e.size() && i < wq.size(); i++)
			chk("buffer write", e[i], wq[i]);
		chk("current page", expCur, currentPagePointer);
	endtask
	task automatic waitTx;
		int t;
		for (t = 0; t < 9000 && txEnable !== 1'b1; t++)
			@(negedge core_clk);
		chk("tx started", 1, txEnable);
	endtask
	task automatic txRequest;
		transmitRequest = 1'b1;
		@(negedge core_clk);
		transmitRequest = 1'b0;
	endtask
	// collide forty cycles into an attempt
	task automatic hit;
		waitTx;
		repeat (40) @(negedge core_clk);
		collision = 1'b1;
		repeat (6) @(negedge core_clk);
		collision = 1'b0;
		repeat (20) @(negedge core_clk);
	endtask
	// sample each serial bit mid-cell against preamble, image and crc
	task automatic txCheck(input int n);
		logic [31:0] crc;
		logic [15:0] a;
		logic        b;
		int          i, k;
		crc = 32'hFFFFFFFF;
		a = {txPageStart, 8'h00};
		waitTx;
		repeat (12) @(negedge core_clk);
		for (i = -8; i < n + 4; i++)
			for (k = 0; k < 8; k++) begin
				if (i < 0)
					b = !k[0] || (i == -1 && k == 7);
				else if (i < n)
					b = pat(a + 16'(i)) >> k;
				else
					b = !crc[(i - n) * 8 + k];
				if (i >= 0 && i < n)
					crc = (crc >> 1) ^ ((crc[0] ^ b) ? 32'hEDB88320 : 32'h00000000);
				chk("line bit", b, txData);
				repeat (25) @(negedge core_clk);
			end
		chk("line idle", 0, txEnable);
		repeat (4) @(negedge core_clk);
		chk("tx result", 2'b10, {txDone, txUnderrun});
	endtask
	// main sequence
	initial begin
		repeat (6) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("reset state", 0, {currentPagePointer, txEnable, txDone, txAborted, memWrEn});
		curLoad = 1'b1;
		@(negedge core_clk);
		curLoad = 1'b0;
		expCur = 8'h5F;
		for (m = 0; m < 3; m++) begin
			{wordTransferSelect, byteOrderSelect} = {m != 0, m == 2};
			{acceptRunt, acceptErrors} = 2'b00;
			rxFrame(20 + m, 3'b000, 1'b1);
			rxFrame(30, 3'b100 >> m, 1'b0);
			{acceptRunt, acceptErrors} = {m == 0, m != 0};
			rxFrame(300, 3'b100 >> m, 1'b1);
		end
		for (m = 0; m < 3; m++) begin
			{wordTransferSelect, byteOrderSelect, slow} = {m != 0, m == 2, m == 1};
			txPageStart = 8'h10 + 8'(m);
			{rxActive, carrierSense} = {m == 1, m == 2};
			txSeen = 1'b0;
			txRequest;
			if (m != 0) begin
				repeat (300) @(negedge core_clk);
				chk("held off", 0, txSeen);
				{rxActive, carrierSense} = 2'b00;
			end
			if (m == 0) begin
				hit;
				chk("first collision", 5'h11, {txCollided, collisionCount});
			end
			txCheck(60);
			chk("retries", m == 0, collisionCount);
		end
		txRequest;
		for (m = 0; m < 16; m++) begin
			hit;
			chk("aborted", m == 15, txAborted);
		end
		chk("count after abort", 5'h00, {txEnable, collisionCount});
		printVerdict;
	end
	// watchdog
	initial begin
		repeat (95000) @(posedge core_clk);
		nMismatch++;
		printVerdict;
	end
endmodule // pbd_packet_buffer_dma_tb
